// *** strap_led_pkg.sv ***
// Shared constants for the address strap and activity indicator pins
package strap_led_pkg;
  localparam int addr_width = 5;
  localparam int addr_tx_bit = 3;
  localparam int addr_rx_bit = 4;
  localparam logic [4:0] addr_reset_value = 5'h00;
  localparam logic pin_reset_value = 1'h0;
  localparam int ref_clk_mhz = 25;
  localparam int core_clk_mhz = 200;
  localparam int sample_settle_ns = 20;
  localparam int sample_settle_cycles = (sample_settle_ns * core_clk_mhz + 999) / 1000;
  typedef enum logic [1:0] {st_reset, st_sample, st_run} pin_state_t;
endpackage

// *** strap_capture.sv ***
// Strap capture register: latches a pin level on each capture pulse and holds it
module strap_capture
  import strap_led_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Capture control
  input wire logic capture,
  input wire logic pin_level,
  // Held value
  output logic strap_value
);
  // Holds each captured level until the next capture or reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      strap_value <= pin_reset_value;
    else if (capture)
      strap_value <= pin_level;
  end
endmodule

// *** phy_addr_strap_led_pins.sv ***
// Multi-function address strap and activity indicator pins
module phy_addr_strap_led_pins
  import strap_led_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Reset pin
  input wire logic hw_reset_n,
  // Transmit strap / indicator pin
  input wire logic addr3_tx_activity_pin_in,
  output logic addr3_tx_activity_pin_out,
  output logic addr3_tx_activity_pin_oe,
  // Receive strap / indicator pin
  input wire logic addr4_rx_activity_pin_in,
  output logic addr4_rx_activity_pin_out,
  output logic addr4_rx_activity_pin_oe,
  // Core status
  input wire logic tx_activity,
  input wire logic rx_activity,
  input wire logic speed_100_sel,
  // Management address match, speed select output and PHY address
  input wire logic [4:0] frame_phy_addr,
  input wire logic [2:0] addr_low_bits,
  output logic addr_match,
  output logic speed_select_out,
  output logic [4:0] phy_addr
);
  pin_state_t state_reg, state_next;
  logic [7:0] settle_reg;
  logic [7:0] settle_next;
  logic strap_tx, strap_rx;

  // Settle counter is eight bits, so the window must fit in it
  if (sample_settle_cycles < 1 || sample_settle_cycles > 256)
  begin : settle_range_check
    $error("settle window does not fit the counter");
  end
  // Address is built by concatenation, so strap positions are fixed
  if (addr_width != 5 || addr_tx_bit != 3 || addr_rx_bit != 4)
  begin : strap_position_check
    $error("strap bit positions do not match the address layout");
  end
  // Core clock is derived from the reference, so a whole multiple is needed
  if (core_clk_mhz % ref_clk_mhz != 0)
  begin : clock_ratio_check
    $error("core clock is not a multiple of the reference");
  end

  // Reset pin is synchronous to core_clk; low forces reset state
  wire in_hw_reset = !hw_reset_n;
  wire settle_done = (settle_reg == 8'(sample_settle_cycles - 1));
  wire capture = (state_reg == st_sample) && settle_done && !in_hw_reset;
  wire [4:0] addr_full = {strap_rx, strap_tx, addr_low_bits};
  wire match_next = (state_reg == st_run) && (frame_phy_addr == addr_full);

  // Drive decision from the next state, so direction and level move together
  wire drive_next = (state_next == st_run);
  wire tx_led_next = drive_next && tx_activity;
  wire rx_led_next = drive_next && rx_activity;

  // Next state: reset, settle while straps sampled, then run
  always_comb
  begin
    state_next = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      st_reset:
      begin
        settle_next = 8'h00;
        if (!in_hw_reset)
          state_next = st_sample;
      end
      st_sample:
      begin
        settle_next = settle_reg + 8'h01;
        if (in_hw_reset)
          state_next = st_reset;
        else if (settle_done)
          state_next = st_run;
      end
      st_run:
        if (in_hw_reset)
          state_next = st_reset;
      default:
        state_next = st_reset;
    endcase
  end

  // State and counter
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= st_reset;
      settle_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      settle_reg <= settle_next;
    end
  end

  // Strap latches; pins still undriven when captured
  strap_capture tx_strap (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .capture(capture),
    .pin_level(addr3_tx_activity_pin_in),
    .strap_value(strap_tx)
  );
  strap_capture rx_strap (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .capture(capture),
    .pin_level(addr4_rx_activity_pin_in),
    .strap_value(strap_rx)
  );

  // Output drivers; enable only after strap capture so LEDs never corrupt it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr3_tx_activity_pin_out <= 1'h0;
      addr4_rx_activity_pin_out <= 1'h0;
      addr3_tx_activity_pin_oe <= 1'h0;
      addr4_rx_activity_pin_oe <= 1'h0;
      speed_select_out <= 1'h0;
      addr_match <= 1'h0;
      phy_addr <= addr_reset_value;
    end
    else
    begin
      addr3_tx_activity_pin_oe <= drive_next;
      addr4_rx_activity_pin_oe <= drive_next;
      addr3_tx_activity_pin_out <= tx_led_next;
      addr4_rx_activity_pin_out <= rx_led_next;
      speed_select_out <= speed_100_sel;
      addr_match <= match_next;
      phy_addr <= addr_full;
    end
  end

  // Checks
  sequence leaving_reset_s;
    (state_reg == st_sample) && settle_done && !in_hw_reset;
  endsequence

  pins_input_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    in_hw_reset |=> !addr3_tx_activity_pin_oe && !addr4_rx_activity_pin_oe)
    else $error("indicator pin driven during reset");
  pins_drive_run_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    leaving_reset_s |=> addr3_tx_activity_pin_oe && addr4_rx_activity_pin_oe)
    else $error("indicator pin not driven after reset");
  tx_strap_bit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    leaving_reset_s |=> ##1 phy_addr[addr_tx_bit] == $past(addr3_tx_activity_pin_in, 2))
    else $error("address bit 3 not from transmit strap");
  rx_strap_bit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    leaving_reset_s |=> ##1 phy_addr[addr_rx_bit] == $past(addr4_rx_activity_pin_in, 2))
    else $error("address bit 4 not from receive strap");
  tx_led_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == st_run && !in_hw_reset) |=> addr3_tx_activity_pin_out == $past(tx_activity))
    else $error("transmit indicator mismatch");
  rx_led_follow_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == st_run && !in_hw_reset) |=> addr4_rx_activity_pin_out == $past(rx_activity))
    else $error("receive indicator mismatch");
  speed_out_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 speed_select_out == $past(speed_100_sel))
    else $error("speed select output mismatch");
  reset_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    in_hw_reset |=> state_reg == st_reset)
    else $error("left reset while reset pin low");
  strap_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == st_run && $past(state_reg) == st_run) |-> $stable(strap_tx) && $stable(strap_rx))
    else $error("strap bits changed after reset");
  addr_match_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == st_run && frame_phy_addr != addr_full) |=> !addr_match)
    else $error("match on wrong address");

  // Pin direction, strap window and address match
  sequence entering_reset_s;
    in_hw_reset;
  endsequence

  sequence settling_s;
    (state_reg == st_sample) && !settle_done && !in_hw_reset;
  endsequence

  sequence address_hit_s;
    (state_reg == st_run) && (frame_phy_addr == addr_full);
  endsequence

  oe_tracks_run_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    addr3_tx_activity_pin_oe == (state_reg == st_run) && addr4_rx_activity_pin_oe == (state_reg == st_run))
    else $error("indicator pin direction out of step with state");
  led_dark_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    entering_reset_s |=> !addr3_tx_activity_pin_out && !addr4_rx_activity_pin_out)
    else $error("indicator lit during reset");
  settle_released_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    settling_s |=> state_reg == st_sample && !addr3_tx_activity_pin_oe && !addr4_rx_activity_pin_oe)
    else $error("strap pin driven while being sampled");
  release_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg == st_reset && !in_hw_reset) |=> state_reg == st_sample && settle_reg == 8'h00)
    else $error("reset release did not start the strap window");
  strap_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !capture |=> $stable(strap_tx) && $stable(strap_rx))
    else $error("strap bit moved without a capture");
  strap_to_addr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 phy_addr[addr_tx_bit] == $past(strap_tx) && phy_addr[addr_rx_bit] == $past(strap_rx))
    else $error("address strap bits differ from latched levels");
  low_bits_pass_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 phy_addr[2:0] == $past(addr_low_bits))
    else $error("low address bits differ from input");
  addr_match_hit_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    address_hit_s |=> addr_match)
    else $error("no match on own address");
  match_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_reg != st_run) |=> !addr_match)
    else $error("match reported outside run");
endmodule

// *** strap_board_model.sv ***
// Board model: strap resistors and indicator LEDs on the two pins
module strap_board_model (
  // Strap resistor levels
  input wire logic strap3_high,
  input wire logic strap4_high,
  // Pin drivers of the block
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic rx_out,
  input wire logic rx_oe,
  // Resolved pad levels
  output logic tx_pad,
  output logic rx_pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // Resistor sets the level only while the block lets go of the pin
  assign tx_pad = tx_oe ? tx_out : strap3_high;
  assign rx_pad = rx_oe ? rx_out : strap4_high;
endmodule

// *** phy_addr_strap_led_pins_tb_top.sv ***
// Bench for the address strap and activity indicator pins
module phy_addr_strap_led_pins_tb_top import strap_led_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, reset_n = 0, hw_reset_n = 0, s3 = 0, s4 = 0, tx_pad, rx_pad;
  logic tx_out, tx_oe, rx_out, rx_oe, tx_act = 0, rx_act = 0, spd = 0, match, spd_out;
  logic [4:0] frame = 5'h00, phy_addr;
  logic [2:0] low = 3'h0;
  int errors = 0, tests_run = 0, cycles = 0;
  // 200 MHz core clock; the 25 MHz reference is not modelled here
  always #2.5 core_clk = ~core_clk;
  strap_board_model board (.strap3_high(s3), .strap4_high(s4), .tx_out(tx_out), .tx_oe(tx_oe),
    .rx_out(rx_out), .rx_oe(rx_oe), .tx_pad(tx_pad), .rx_pad(rx_pad));
  phy_addr_strap_led_pins uut (.core_clk(core_clk), .reset_n(reset_n), .hw_reset_n(hw_reset_n),
    .addr3_tx_activity_pin_in(tx_pad), .addr3_tx_activity_pin_out(tx_out), .addr3_tx_activity_pin_oe(tx_oe),
    .addr4_rx_activity_pin_in(rx_pad), .addr4_rx_activity_pin_out(rx_out), .addr4_rx_activity_pin_oe(rx_oe),
    .tx_activity(tx_act), .rx_activity(rx_act), .speed_100_sel(spd), .frame_phy_addr(frame),
    .addr_low_bits(low), .addr_match(match), .speed_select_out(spd_out), .phy_addr(phy_addr));
  task automatic check(input logic [4:0] seen, input logic [4:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Let the edge's register updates land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Pin reset with given straps, then read back the latched address
  task automatic strap_reset(input logic a3, input logic a4, input logic [2:0] lb);
    @(posedge core_clk);
    hw_reset_n <= 0;
    tx_act <= 1;
    rx_act <= 1;
    s3 <= a3;
    s4 <= a4;
    low <= lb;
    settle(3);
    check({tx_oe, rx_oe}, 5'h00, "oe in reset");
    check({tx_out, rx_out}, 5'h00, "out in reset");
    @(posedge core_clk);
    hw_reset_n <= 1;
    settle(8);
    check({tx_oe, rx_oe}, 5'h03, "oe after reset");
    check(phy_addr, {a4, a3, lb}, "phy_addr");
  endtask
  // Indicators follow activity; driving against the straps must not move the address
  task automatic activity_test();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      tx_act <= i[0];
      rx_act <= i[1];
      settle(2);
      check(tx_out, i[0], "tx indicator");
      check(rx_out, i[1], "rx indicator");
      check(phy_addr, {s4, s3, low}, "held address");
    end
  endtask
  // Speed output level and address match, hit and one bit off
  task automatic speed_match_test();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge core_clk);
      spd <= i[0];
      frame <= {s4, s3, low} ^ {4'h0, i[0]};
      settle(2);
      check(spd_out, i[0], "speed select");
      check(match, !i[0], "addr match");
    end
  endtask
  // Hang guard well above the expected run length
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1;
    for (int i = 0; i < 4; i++)
    begin
      strap_reset(i[0], i[1], 3'(i + 5));
      activity_test();
      speed_match_test();
    end
    close_out();
  end
endmodule
